// [efo_pkg.sv]
// constants for the stage block
// assumes a 50 MHz clock and residual values scaled to 0.001 pu per lsb
package efo_pkg;
    localparam int NUM_STAGES = 4;
    localparam int NUM_GROUPS = 4;
    // delays count 10 ms ticks
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_NS = 10000000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_INV = 8'h10;
    localparam logic [7:0] ADDR_BETA = 8'h14;
    localparam logic [3:0] ADDR_CFG_PAGE = 4'h2;
    localparam logic [1:0] ADDR_SET_PAGE = 2'h1;
    localparam logic [3:0] ADDR_MULT_PAGE = 4'h8;
    // field positions
    localparam int CTRL_GROUP_LSB = 0;
    localparam int CTRL_FPD_BIT = 2;
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_EVT_BIT = 2;
    localparam int INV_MODE_BIT = 0;
    localparam int INV_FAMILY_LSB = 1;
    localparam int INV_TYPE_LSB = 4;
    localparam int SET_DELAY_LSB = 16;
    localparam int STATE_TRIP_LSB = 4;
    localparam int STATE_PHASE_LSB = 8;
    // residual sources
    localparam logic [1:0] SRC_INPUT1 = 2'h0;
    localparam logic [1:0] SRC_INPUT2 = 2'h1;
    localparam logic [1:0] SRC_CALC = 2'h2;
    // curve families and types
    localparam logic [2:0] FAM_DEFINITE = 3'h0;
    localparam logic [2:0] FAM_IEC = 3'h1;
    localparam logic [2:0] FAM_IEEE = 3'h2;
    localparam logic [2:0] FAM_IEEE2 = 3'h3;
    localparam logic [2:0] FAM_PROG = 3'h4;
    localparam logic [2:0] FAM_LOG = 3'h5;
    localparam logic [15:0] BETA_EXTREMELY = 16'h1F40;
    localparam logic [15:0] BETA_VERY = 16'h0546;
    localparam logic [15:0] BETA_NORMAL = 16'h000E;
    localparam logic [15:0] BETA_LONG = 16'h2EE0;
    localparam logic [15:0] BETA_MODERATE = 16'h0005;
    // setting limits
    localparam logic [15:0] THR_FIRST_MIN = 16'h0005;
    localparam logic [15:0] THR_OTHER_MIN = 16'h000A;
    localparam logic [15:0] THR_MEAS_MAX = 16'h1F40;
    localparam logic [15:0] THR_CALC_MAX = 16'h4E20;
    localparam logic [14:0] DELAY_MIN = 15'h0004;
    localparam logic [14:0] DELAY_MAX = 15'h7530;
    localparam logic [14:0] MULT_MIN = 15'h0019;
    localparam logic [14:0] MULT_MIN_IEEE = 15'h01F4;
    localparam logic [14:0] MULT_MAX = 15'h4E20;
    // saturation at ten times nominal, squared
    localparam logic [36:0] SAT_SQ = 37'h0005F5E100;
    // drop-off at 0.95, squared as 231/256
    localparam logic [36:0] DROP_NUM = 37'h00000000E7;
    localparam int DROP_SHIFT = 8;
    localparam logic [63:0] INV_SCALE = 64'h00000000000003E8;
    // reset values
    localparam logic [15:0] RST_THRESHOLD = 16'h03E8;
    localparam logic [14:0] RST_DELAY = 15'h0064;
    localparam logic [14:0] RST_MULT = 15'h03E8;
    localparam logic [15:0] RST_BETA = 16'h1F40;
endpackage

// [efo_stages.sv]
// four earth fault stages with apb settings
// assumes same-clock fundamental phasors with a sample strobe
// Operation
// - stage starts when fundamental residual magnitude exceeds its threshold
// - trip after start persisted longer than operate delay, except at minimum delay
// - only third-harmonic-free fundamental phasors drive start decisions
// - each stage selects input one, input two or calculated residual
// - calculated residual is vector sum of three phase currents
// - four stages; only the first may use inverse delay
// - stages two to four are definite delay only
// - definite delay at minimum gives instantaneous operation
// - four setting groups per stage; active group feeds stages
// - first stage threshold 0.005-8.00 pu measured, up to 20.0 calculated
// - other thresholds 0.01-8.00 pu in 0.01 steps on measured inputs
// - definite delays 0.04-299.99 s in 0.01 s steps; settings of 300.00 s and above never trip
// - first stage inverse curve family and curve type selectable
// - multiplier 0.025-20.0, at least 0.50 for ieee and log families
// - inverse integration saturates at ten times residual nominal
// - faulty phase detection from prior and fault phase currents
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
module efo_stages
    import efo_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sampleValid,
    input wire logic signed [15:0] residual1Re,
    input wire logic signed [15:0] residual1Im,
    input wire logic signed [15:0] residual2Re,
    input wire logic signed [15:0] residual2Im,
    input wire logic signed [15:0] phaseARe,
    input wire logic signed [15:0] phaseAIm,
    input wire logic signed [15:0] phaseBRe,
    input wire logic signed [15:0] phaseBIm,
    input wire logic signed [15:0] phaseCRe,
    input wire logic signed [15:0] phaseCIm,
    input wire logic [3:0] stageBlock,
    output logic [3:0] stageStart,
    output logic [3:0] stageTrip,
    output logic [2:0] faultyPhase,
    output logic irq
);
    // squared magnitude of an 18-bit phasor
    function automatic logic [36:0] magSq(input logic signed [17:0] re, input logic signed [17:0] im);
        logic signed [35:0] a;
        logic signed [35:0] b;
        a = re * re;
        b = im * im;
        magSq = {1'b0, a} + {1'b0, b};
    endfunction

    function automatic logic signed [17:0] ext(input logic signed [15:0] v);
        ext = {{2{v[15]}}, v};
    endfunction

    logic [1:0] group_q;
    logic fpdEnable_q;
    logic [7:0] event_q;
    logic [7:0] mask_q;
    logic invMode_q;
    logic [2:0] family_q;
    logic [2:0] curveType_q;
    logic [15:0] progBeta_q;
    logic [1:0] source_q [NUM_STAGES];
    logic eventEn_q [NUM_STAGES];
    logic [15:0] thrSet_q [NUM_STAGES * NUM_GROUPS];
    logic [14:0] delaySet_q [NUM_STAGES * NUM_GROUPS];
    logic [14:0] mult_q [NUM_GROUPS];
    logic [31:0] tickCnt_q;
    logic tick_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;
    logic [2:0] faulty_q;
    logic [36:0] prior_q [3];
    logic [36:0] sqIn1;
    logic [36:0] sqIn2;
    logic [36:0] sqCalc;
    logic [36:0] phSq [3];
    logic signed [15:0] phRe [3];
    logic signed [15:0] phIm [3];
    logic [3:0] startVec;
    logic [3:0] tripVec;
    logic [3:0] startEvt;
    logic [3:0] tripEvt;
    logic [3:0] evtEnVec;
    logic access;
    logic done;
    logic mapped;
    logic wrEn;
    logic rdEn;
    logic [31:0] rdata;
    logic [3:0] setIdx;
    logic anyStartRise;
    logic anyTripRise;

    // source magnitudes from fundamental phasors
    assign sqIn1 = magSq(ext(residual1Re), ext(residual1Im));
    assign sqIn2 = magSq(ext(residual2Re), ext(residual2Im));
    assign sqCalc = magSq(ext(phaseARe) + ext(phaseBRe) + ext(phaseCRe),
                          ext(phaseAIm) + ext(phaseBIm) + ext(phaseCIm));
    assign phRe[0] = phaseARe;
    assign phRe[1] = phaseBRe;
    assign phRe[2] = phaseCRe;
    assign phIm[0] = phaseAIm;
    assign phIm[1] = phaseBIm;
    assign phIm[2] = phaseCIm;

    // apb decode, one wait state
    assign access = psel & penable;
    assign done = access & pready_q;
    assign setIdx = paddr[5:2];
    assign wrEn = done & pwrite & mapped;
    assign rdEn = done & ~pwrite & mapped;

    always_comb
    begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'h0)
        begin
            if (paddr <= ADDR_BETA || paddr[7:4] == ADDR_CFG_PAGE || paddr[7:6] == ADDR_SET_PAGE
                || paddr[7:4] == ADDR_MULT_PAGE)
            begin
                mapped = 1'b1;
            end
        end
    end

    // read mux
    always_comb
    begin
        rdata = 32'h00000000;
        if (paddr[7:6] == ADDR_SET_PAGE)
        begin
            rdata[15:0] = thrSet_q[setIdx];
            rdata[SET_DELAY_LSB +: 15] = delaySet_q[setIdx];
        end
        else if (paddr[7:4] == ADDR_CFG_PAGE)
        begin
            rdata[CFG_SRC_LSB +: 2] = source_q[paddr[3:2]];
            rdata[CFG_EVT_BIT] = eventEn_q[paddr[3:2]];
        end
        else if (paddr[7:4] == ADDR_MULT_PAGE)
        begin
            rdata[14:0] = mult_q[paddr[3:2]];
        end
        else
        begin
            case (paddr)
                ADDR_CTRL:
                begin
                    rdata[CTRL_GROUP_LSB +: 2] = group_q;
                    rdata[CTRL_FPD_BIT] = fpdEnable_q;
                end
                ADDR_STATE:
                begin
                    rdata[3:0] = startVec;
                    rdata[STATE_TRIP_LSB +: 4] = tripVec;
                    rdata[STATE_PHASE_LSB +: 3] = faulty_q;
                end
                ADDR_EVENT: rdata[7:0] = event_q;
                ADDR_MASK: rdata[7:0] = mask_q;
                ADDR_INV:
                begin
                    rdata[INV_MODE_BIT] = invMode_q;
                    rdata[INV_FAMILY_LSB +: 3] = family_q;
                    rdata[INV_TYPE_LSB +: 3] = curveType_q;
                end
                ADDR_BETA: rdata[15:0] = progBeta_q;
                default: ;
            endcase
        end
    end

    // bus handshake and answer
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= access & ~pready_q;
            if (access & ~pready_q)
            begin
                prdata_q <= mapped ? rdata : 32'h00000000;
                pslverr_q <= ~mapped;
            end
            else
            begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // global and inverse settings
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            group_q <= 2'h0;
            fpdEnable_q <= 1'b0;
            mask_q <= 8'h00;
            invMode_q <= 1'b0;
            family_q <= FAM_DEFINITE;
            curveType_q <= 3'h0;
            progBeta_q <= RST_BETA;
        end
        else if (wrEn)
        begin
            case (paddr)
                ADDR_CTRL:
                begin
                    group_q <= pwdata[CTRL_GROUP_LSB +: 2];
                    fpdEnable_q <= pwdata[CTRL_FPD_BIT];
                end
                ADDR_MASK: mask_q <= pwdata[7:0];
                ADDR_INV:
                begin
                    invMode_q <= pwdata[INV_MODE_BIT];
                    family_q <= pwdata[INV_FAMILY_LSB +: 3];
                    curveType_q <= pwdata[INV_TYPE_LSB +: 3];
                end
                ADDR_BETA: progBeta_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // setting storage
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_STAGES * NUM_GROUPS; i++)
            begin
                thrSet_q[i] <= RST_THRESHOLD;
                delaySet_q[i] <= RST_DELAY;
            end
            for (int i = 0; i < NUM_STAGES; i++)
            begin
                source_q[i] <= SRC_INPUT1;
                eventEn_q[i] <= 1'b0;
                mult_q[i] <= RST_MULT;
            end
        end
        else if (wrEn)
        begin
            if (paddr[7:6] == ADDR_SET_PAGE)
            begin
                thrSet_q[setIdx] <= pwdata[15:0];
                delaySet_q[setIdx] <= pwdata[SET_DELAY_LSB +: 15];
            end
            else if (paddr[7:4] == ADDR_CFG_PAGE)
            begin
                source_q[paddr[3:2]] <= pwdata[CFG_SRC_LSB +: 2];
                eventEn_q[paddr[3:2]] <= pwdata[CFG_EVT_BIT];
            end
            else if (paddr[7:4] == ADDR_MULT_PAGE)
            begin
                mult_q[paddr[3:2]] <= pwdata[14:0];
            end
        end
    end

    // 10 ms timebase shared by all delay timers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tickCnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (tickCnt_q == 32'(TICK_LEN - 1));
            tickCnt_q <= (tickCnt_q == 32'(TICK_LEN - 1)) ? 32'h00000000 : tickCnt_q + 32'h00000001;
        end
    end

    // four stages
    for (genvar s = 0; s < NUM_STAGES; s++)
    begin : gStage
        logic [15:0] thrRaw;
        logic [15:0] thrEff;
        logic [15:0] thrLo;
        logic [15:0] thrHi;
        logic [14:0] dlyEff;
        logic [36:0] pick;
        logic [36:0] thrSq;
        logic [36:0] dropSq;
        logic [73:0] dropProd;
        logic start_q;
        logic trip_q;
        logic [14:0] dlyCnt_q;
        logic start_d;
        logic trip_d;
        logic dtDone;
        logic invActive;
        logic invDone;

        always_comb
        begin
            thrRaw = thrSet_q[s * NUM_GROUPS + int'(group_q)];
            dlyEff = delaySet_q[s * NUM_GROUPS + int'(group_q)];
            if (dlyEff < DELAY_MIN)
            begin
                dlyEff = DELAY_MIN;
            end
            else if (dlyEff > DELAY_MAX)
            begin
                dlyEff = DELAY_MAX;
            end
            thrHi = (source_q[s] == SRC_CALC || source_q[s] == 2'h3) ? THR_CALC_MAX : THR_MEAS_MAX;
            thrLo = (s == 0 || thrHi == THR_CALC_MAX) ? THR_FIRST_MIN : THR_OTHER_MIN;
            thrEff = (thrRaw < thrLo) ? thrLo : ((thrRaw > thrHi) ? thrHi : thrRaw);
            if (thrLo == THR_OTHER_MIN)
            begin
                thrEff = thrEff - (thrEff % 16'h000A);
            end
            case (source_q[s])
                SRC_INPUT1: pick = sqIn1;
                SRC_INPUT2: pick = sqIn2;
                default: pick = sqCalc;
            endcase
        end

        assign thrSq = {21'h000000, thrEff} * {21'h000000, thrEff};
        assign dropProd = thrSq * DROP_NUM;
        assign dropSq = dropProd[DROP_SHIFT +: 37];
        // minimum delay: instantaneous
        assign dtDone = (dlyEff == DELAY_MIN) ? 1'b1 : (dlyCnt_q > dlyEff);
        assign invActive = (s == 0) && invMode_q && family_q != FAM_DEFINITE && family_q <= FAM_LOG;

        // hysteresis keeps start from chattering at the threshold
        always_comb
        begin
            start_d = start_q;
            if (sampleValid)
            begin
                if (!start_q && pick > thrSq)
                begin
                    start_d = 1'b1;
                end
                else if (start_q && pick < dropSq)
                begin
                    start_d = 1'b0;
                end
            end
            if (stageBlock[s])
            begin
                start_d = 1'b0;
            end
            trip_d = start_d & start_q & (invActive ? invDone : dtDone);
        end

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                start_q <= 1'b0;
                trip_q <= 1'b0;
                dlyCnt_q <= 15'h0000;
            end
            else
            begin
                start_q <= start_d;
                trip_q <= trip_d;
                if (!start_q)
                begin
                    dlyCnt_q <= 15'h0000;
                end
                else if (tick_q && dlyCnt_q != DELAY_MAX)
                begin
                    dlyCnt_q <= dlyCnt_q + 15'h0001;
                end
            end
        end

        if (s == 0)
        begin : gInv
            logic [14:0] multEff;
            logic [14:0] multLo;
            logic [15:0] beta;
            logic [36:0] satSq;
            logic [36:0] diff;
            logic [63:0] target;
            logic [63:0] acc_q;

            always_comb
            begin
                multLo = (family_q == FAM_IEEE || family_q == FAM_IEEE2 || family_q == FAM_LOG)
                         ? MULT_MIN_IEEE : MULT_MIN;
                multEff = mult_q[group_q];
                if (multEff < multLo)
                begin
                    multEff = multLo;
                end
                else if (multEff > MULT_MAX)
                begin
                    multEff = MULT_MAX;
                end
                case (curveType_q)
                    3'h0: beta = BETA_EXTREMELY;
                    3'h1: beta = BETA_VERY;
                    3'h2: beta = BETA_NORMAL;
                    3'h3: beta = BETA_LONG;
                    default: beta = BETA_MODERATE;
                endcase
                if (family_q == FAM_PROG)
                begin
                    beta = progBeta_q;
                end
                satSq = (pick > SAT_SQ) ? SAT_SQ : pick;
                diff = (satSq > thrSq) ? satSq - thrSq : 37'h0000000001;
            end

            // squared-law integration: trips when sum reaches k*beta*Is^2
            assign target = 64'(multEff) * 64'(beta) * 64'(thrSq);
            assign invDone = acc_q >= target;

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                begin
                    acc_q <= 64'h0000000000000000;
                end
                else if (!start_q)
                begin
                    acc_q <= 64'h0000000000000000;
                end
                else if (tick_q && !invDone)
                begin
                    acc_q <= acc_q + 64'(diff) * INV_SCALE;
                end
            end
        end
        else
        begin : gDef
            assign invDone = 1'b0;
        end

        assign startVec[s] = start_q;
        assign tripVec[s] = trip_q;
        assign startEvt[s] = start_d & ~start_q;
        assign tripEvt[s] = trip_d & ~trip_q;
        assign evtEnVec[s] = eventEn_q[s];
        assign stageStart[s] = start_q;
        assign stageTrip[s] = trip_q;
    end

    assign anyStartRise = (startVec == 4'h0) && (startEvt != 4'h0);
    assign anyTripRise = (tripEvt != 4'h0);

    // faulty phase: prior versus trip currents
    for (genvar p = 0; p < 3; p++)
    begin : gPhase
        assign phSq[p] = magSq(ext(phRe[p]), ext(phIm[p]));

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                prior_q[p] <= 37'h0000000000;
                faulty_q[p] <= 1'b0;
            end
            else
            begin
                if (anyStartRise)
                begin
                    prior_q[p] <= phSq[p];
                end
                if (anyTripRise && fpdEnable_q)
                begin
                    faulty_q[p] <= phSq[p] > {prior_q[p][35:0], 1'b0};
                end
            end
        end
    end
    assign faultyPhase = faulty_q;

    // sticky events, a new event beats the read clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            event_q <= 8'h00;
            irq_q <= 1'b0;
        end
        else
        begin
            event_q <= (rdEn && paddr == ADDR_EVENT ? 8'h00 : event_q)
                       | {tripEvt & evtEnVec, startEvt & evtEnVec};
            irq_q <= |(event_q & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule

// [efo_stages_assertions.sv]
// port checker
// assumes binding onto efo_stages, one clock domain
module efo_stages_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sampleValid,
    input wire logic [3:0] stageBlock,
    input wire logic [3:0] stageStart,
    input wire logic [3:0] stageTrip
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // one-cycle bus answer
    apb_wait_a: assert property (pready |-> psel && penable && $past(penable))
        else $error("bad pready");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_resp_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("no refusal");
    // stage outputs
    trip_start_a: assert property ((stageTrip & ~stageStart) == 4'h0)
        else $error("trip without start");
    block_clear_a: assert property (stageBlock != 4'h0 |=> ((stageStart | stageTrip) & $past(stageBlock)) == 4'h0)
        else $error("block ignored");
    start_rise_a: assert property ((stageStart & ~$past(stageStart)) != 4'h0 |-> $past(sampleValid))
        else $error("early start");
    start_fall_a: assert property ((~stageStart & $past(stageStart)) != 4'h0 |->
        $past(sampleValid) || $past(stageBlock) != 4'h0)
        else $error("bad drop");
    trip_rise_a: assert property ((stageTrip & ~$past(stageTrip) & ~$past(stageStart)) == 4'h0)
        else $error("trip before start");
endmodule
bind efo_stages efo_stages_assertions efo_stages_assertions_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleValid(sampleValid), .stageBlock(stageBlock), .stageStart(stageStart), .stageTrip(stageTrip));

// [efo_front_end.sv]
// front end model
// assumes real parts set as levels, imaginary zero
module efo_front_end (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic signed [15:0] in1,
    input wire logic signed [15:0] in2,
    input wire logic signed [15:0] pa,
    input wire logic signed [15:0] pb,
    input wire logic signed [15:0] pc,
    output logic sampleValid,
    output logic signed [15:0] r1,
    output logic signed [15:0] r2,
    output logic signed [15:0] ar,
    output logic signed [15:0] br,
    output logic signed [15:0] cr,
    output logic signed [15:0] im
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q;
    // strobe every eight cycles
    always_ff @(posedge clock)
    begin
        cnt_q <= rst_n ? cnt_q + 3'h1 : 3'h0;
        sampleValid <= rst_n && cnt_q == 3'h7;
    end
    // garbage off the strobe catches stale use
    assign r1 = sampleValid ? in1 : ~in1;
    assign r2 = sampleValid ? in2 : ~in2;
    assign ar = sampleValid ? pa : ~pa;
    assign br = sampleValid ? pb : ~pb;
    assign cr = sampleValid ? pc : ~pc;
    assign im = sampleValid ? 16'h0000 : 16'hFFFF;
endmodule

// [test_efo_stages.sv]
// self-checking bench for the earth fault stages
// assumes a 10-cycle delay tick so operate delays stay short
module test_efo_stages
    import efo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TL = 10;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, sampleValid, irq, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] stageBlock = 4'h0, stageStart, stageTrip, expS;
    logic [2:0] faultyPhase;
    logic signed [15:0] in1 = 16'h0, in2 = 16'h0, pa = 16'h0, pb = 16'h0, pc = 16'h0, r1, r2, ar, br, cr, im;
    int n_fail = 0, n_tests = 0, seed = 93, thr[4], src[4], v, k;
    always #10 clock = ~clock;
    efo_front_end efo_front_end_i (.clock(clock), .rst_n(rst_n), .in1(in1), .in2(in2), .pa(pa), .pb(pb), .pc(pc),
        .sampleValid(sampleValid), .r1(r1), .r2(r2), .ar(ar), .br(br), .cr(cr), .im(im));
    efo_stages #(.TICK_LEN(TL)) efo_stages_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sampleValid(sampleValid), .residual1Re(r1), .residual1Im(im), .residual2Re(r2), .residual2Im(im),
        .phaseARe(ar), .phaseAIm(im), .phaseBRe(br), .phaseBIm(im), .phaseCRe(cr), .phaseCIm(im),
        .stageBlock(stageBlock), .stageStart(stageStart), .stageTrip(stageTrip), .faultyPhase(faultyPhase), .irq(irq));
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
        chk_reg({28'h0, g}, {28'h0, e});
    endtask
    // one transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clock);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        rd = prdata;
        er = pslverr;
        if (i == 20) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic drive(input int a, input int b, input int c, input int d, input int e);
        @(posedge clock);
        in1 <= 16'(a);
        in2 <= 16'(b);
        pa <= 16'(c);
        pb <= 16'(d);
        pc <= 16'(e);
    endtask
    // wait for a sample, step the model
    task automatic sample();
        int s, x, t;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (sampleValid !== 1'b1 && k < 20);
        if (k == 20) n_fail++;
        for (s = 0; s < 4; s++)
        begin
            x = src[s] == 0 ? in1 : src[s] == 1 ? in2 : pa + pb + pc;
            t = thr[s] * thr[s];
            if (stageBlock[s] || x * x < t * 231 / 256) expS[s] = 1'b0;
            else if (x * x > t) expS[s] = 1'b1;
        end
        #1;
    endtask
    task automatic end_of_test();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        thr = '{605, 500, 300, 250};
        src = '{0, 2, 1, 0};
        expS = 4'h0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, 8'h40, 32'h0);
        chk_reg(rd, 32'h006403E8);
        apb(1'b0, 8'h18, 32'h0);
        chk_reg({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h41, 32'h0);
        chk_reg({31'h0, er}, 32'h1);
        for (k = 0; k < 4; k++)
        begin
            apb(1'b1, 8'(32 + 4 * k), {29'h0, k == 0, src[k][1:0]});
            apb(1'b1, 8'(64 + 16 * k), {1'b0, 15'h7530, thr[k][15:0]});
        end
        apb(1'b1, ADDR_MASK, 32'h000000FF);
        $display("test registers done");
        repeat (24)
        begin
            drive($random(seed) % 1300, $random(seed) % 700, $random(seed) % 400, $random(seed) % 400, $random(seed) % 400);
            sample();
            chk_pin(stageStart, expS);
            chk_pin(stageTrip, 4'h0);
        end
        $display("test random done");
        // events only from enabled stages
        drive(0, 0, 0, 0, 0);
        sample();
        apb(1'b0, ADDR_EVENT, 32'h0);
        drive(700, 0, 0, 0, 0);
        sample();
        repeat (2) @(posedge clock);
        #1 chk_pin({3'h0, irq}, 4'h1);
        apb(1'b0, ADDR_EVENT, 32'h0);
        chk_reg(rd, 32'h00000001);
        repeat (2) @(posedge clock);
        #1 chk_pin({3'h0, irq}, 4'h0);
        @(posedge clock);
        stageBlock <= 4'h1;
        sample();
        chk_pin(stageStart, expS);
        @(posedge clock);
        stageBlock <= 4'h0;
        sample();
        chk_pin(stageStart, expS);
        $display("test events done");
        // five-tick delay on stage three
        apb(1'b1, 8'h60, {1'b0, 15'h0005, 16'h012C});
        drive(0, 700, 0, 0, 0);
        sample();
        v = 0;
        while (stageTrip[2] !== 1'b1 && v < 200)
        begin
            @(posedge clock);
            v++;
        end
        chk_reg({31'h0, v > 5 * TL && v <= 6 * TL + 2}, 32'h1);
        drive(0, 0, 0, 0, 0);
        sample();
        apb(1'b1, 8'h40, {1'b0, DELAY_MIN, 16'h025D});
        drive(700, 0, 0, 0, 0);
        sample();
        @(posedge clock);
        #1 chk_pin(stageTrip & 4'h1, 4'h1);
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        thr = '{1000, 1000, 1000, 1000};
        sample();
        chk_pin(stageStart, expS);
        $display("test delays done");
        end_of_test();
    end
    // fires only on a hang
    initial
    begin
        #400000;
        n_fail++;
        end_of_test();
    end
endmodule
